// ===== rtl/ext_edge_sync.sv
// Event pin toggle in its own clock domain, carried across to the system clock
`timescale 1ns/100ps

module ext_edge_sync (
    input  logic ext_clk_i,   // Event pin, used as clock
    input  logic clk_i,       // System clock
    input  logic sys_rst_i,   // Async reset, active high
    output logic edge_o       // One-cycle pulse per pin rising edge
);

    logic              tgl_q;
    logic              tgl_d;
    fg_pkg::edge_sys_s sys_q;
    fg_pkg::edge_sys_s sys_d;

    // Pin domain: flip once per rising edge, nothing else
    always_comb begin
        tgl_d = ~tgl_q;
    end

    always_ff @(posedge ext_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            tgl_q <= 1'b0;
        end else begin
            tgl_q <= tgl_d;
        end
    end

    // Two-flop toggle sync; edge taken from second flop only
    always_comb begin
        sys_d      = sys_q;
        sys_d.sync = {sys_q.sync[0], tgl_q};
        sys_d.last = sys_q.sync[1];
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sys_q <= '0;
        end else begin
            sys_q <= sys_d;
        end
    end

    // Pin edges must be spaced wider than one system clock
    assign edge_o = sys_q.sync[1] ^ sys_q.last;

endmodule

// ===== rtl/fg_cfg.svh
// Offsets, field positions, reset values and timing figures of the fuel gauge
`ifndef FG_CFG_SVH
`define FG_CFG_SVH

// Register pointer values (high byte at the even address)
`define FG_ADDR_VOLT      8'h02
`define FG_ADDR_CHARGE    8'h04
`define FG_ADDR_QSTART    8'h06
`define FG_ADDR_REV       8'h08
`define FG_ADDR_COMP      8'h0c
`define FG_ADDR_RESET     8'hfe

// Bus address and command words
`define FG_SLAVE_ADDR     7'h36
`define FG_QSTART_CMD     16'h4000
`define FG_POR_CMD        16'h5400
`define FG_COMP_RST       16'h9700

// Voltage field sits above this many zero bits
`define FG_VOLT_LSB       4

// Clock rates and times in their own units
`define FG_CLK_HZ         10000000
`define FG_TB_HZ          32768
`define FG_CONV_FIRST_MS  125
`define FG_CONV_LATER_MS  500
`define FG_SLEEP_MIN_MS   1750
`define FG_SLEEP_MAX_MS   2500
`define FG_SLEEP_MS       2000

// Derived counts: timebase ticks per time, clock cycles per tick (rounds down)
`define FG_MS_TICKS(ms)   ((ms) * `FG_TB_HZ / 1000)
`define FG_DIV_CYC        (`FG_CLK_HZ / `FG_TB_HZ)

// Charge mapping: empty-cell code and charge-register-counts-per-code slope
`define FG_VEMPTY         2400
`define FG_SOC_SCALE      68

`endif

// ===== rtl/fg_pkg.sv
// Types shared by the fuel gauge control logic
`include "fg_cfg.svh"

package fg_pkg;

    // Two-wire bus phase, Gray coded along idle-addr-ptr-write
    typedef enum logic [2:0] {
        PH_IDLE  = 3'h0,
        PH_ADDR  = 3'h1,
        PH_PTR   = 3'h3,
        PH_WDATA = 3'h2,
        PH_RDATA = 3'h6,
        PH_SKIP  = 3'h7
    } phase_e;

    // Bus line levels as seen at the pins
    typedef struct packed {
        logic scl;
        logic sda;
    } twi_s;

    // Whole state of the control block
    typedef struct packed {
        logic [1:0]  scl_sy;
        logic [1:0]  sda_sy;
        logic [1:0]  sel_sy;
        logic        scl_p;
        logic        sda_p;
        phase_e      phase;
        logic [3:0]  bit_cnt;
        logic [7:0]  shift;
        logic [7:0]  tx;
        logic [7:0]  ptr;
        logic [7:0]  hold;
        logic        hold_ok;
        logic [7:0]  snap;
        logic        snap_ok;
        logic        oe;
        logic [8:0]  div;
        logic [16:0] sleep_cnt;
        logic        asleep;
        logic [15:0] conv_cnt;
        logic        first;
        logic [25:0] acc;
        logic [11:0] volt;
        logic [15:0] soc;
        logic        soc_valid;
        logic [15:0] comp;
    } gauge_s;

    // Power-on value; bus lines assumed idle high
    localparam gauge_s GAUGE_RST = '{
        scl_sy: 2'h3, sda_sy: 2'h3, scl_p: 1'b1, sda_p: 1'b1,
        phase: PH_IDLE, first: 1'b1, comp: `FG_COMP_RST, default: '0};

    // Clock-domain side of the event pin crossing
    typedef struct packed {
        logic [1:0] sync;
        logic       last;
    } edge_sys_s;

endpackage

// ===== rtl/fuel_gauge_control_regs.sv
// Fuel gauge control: two-wire register slave, timebase, sleep, quick-start
`timescale 1ns/100ps
`include "fg_cfg.svh"

module fuel_gauge_control_regs #(
    parameter int unsigned CONV_FIRST_TICKS = `FG_MS_TICKS(`FG_CONV_FIRST_MS),
    parameter int unsigned CONV_LATER_TICKS = `FG_MS_TICKS(`FG_CONV_LATER_MS),
    parameter int unsigned SLEEP_TICKS      = `FG_MS_TICKS(`FG_SLEEP_MS),
    parameter logic [15:0] REVISION         = 16'h00a5  // Arbitrary revision code
) (
    input  logic         clk_i,                  // System clock, 10 MHz
    input  logic         sys_rst_i,              // Async reset, active high
    input  logic         event_clock_pin_i,      // Event pin: edges or timebase
    input  logic         clock_source_select_i,  // High selects pin as timebase
    input  fg_pkg::twi_s twi_i,                  // Bus line levels
    input  logic [11:0]  adc_sample_i,           // Cell voltage sample
    output logic         sda_o,                  // Data line value when driven
    output logic         sda_oe_o,               // Data line pulled low
    output logic         int_osc_en_o,           // Internal oscillator running
    output logic         asleep_o                // Sleep state
);

    localparam int unsigned DIV_CYC  = `FG_DIV_CYC;
    localparam int unsigned FIRST_SH = $clog2(CONV_FIRST_TICKS);
    localparam int unsigned LATER_SH = $clog2(CONV_LATER_TICKS);

    fg_pkg::gauge_s q;
    fg_pkg::gauge_s n;

    logic        ext_edge;
    logic        sel;
    logic        scl_rise;
    logic        sda_rise;
    logic        bus_start;
    logic        bus_stop;
    logic        tick;
    logic        conv_end;
    logic        qs_req;
    logic        por;
    logic        commit;
    logic [7:0]  waddr;
    logic [15:0] wword;
    logic [25:0] acc_sum;
    logic [11:0] volt_new;
    logic [15:0] rd_word;

    // Clamp a signed estimate into the register range
    function automatic logic [15:0] sat16(input int v);
        if (v < 0) begin
            return 16'h0000;
        end
        if (v > 65535) begin
            return 16'hffff;
        end
        return v[15:0];
    endfunction

    // Charge from a voltage code, linear above empty
    function automatic logic [15:0] soc_map(input logic [11:0] v);
        return sat16((int'(v) - `FG_VEMPTY) * `FG_SOC_SCALE);
    endfunction

    // Register word at a pointer; odd pointers see the same pair
    function automatic logic [15:0] reg_word(input logic [7:0]  a,
                                             input logic [11:0] v,
                                             input logic [15:0] s,
                                             input logic [15:0] c);
        unique case ({a[7:1], 1'b0})
            `FG_ADDR_VOLT:   return {v, `FG_VOLT_LSB'(0)};
            `FG_ADDR_CHARGE: return s;
            `FG_ADDR_REV:    return REVISION;
            `FG_ADDR_COMP:   return c;
            default:         return 16'h0000;
        endcase
    endfunction

    ext_edge_sync u_edge (
        .ext_clk_i (event_clock_pin_i),
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .edge_o    (ext_edge)
    );

    // Line events from the second sync flop and its delayed copy
    assign sel       = q.sel_sy[1];
    assign scl_rise  = q.scl_sy[1] & ~q.scl_p;
    assign sda_rise  = q.sda_sy[1] & ~q.sda_p;
    assign bus_start = q.scl_sy[1] & q.scl_p & q.sda_p & ~q.sda_sy[1];
    assign bus_stop  = q.scl_sy[1] & q.scl_p & ~q.sda_p & q.sda_sy[1];

    // Timebase tick; sleep stops both sources
    assign int_osc_en_o = ~sel & ~q.asleep;
    assign tick = ~q.asleep & (sel ? ext_edge : (q.div == 9'(DIV_CYC - 1)));
    assign conv_end = tick & (q.conv_cnt ==
        (q.first ? 16'(CONV_FIRST_TICKS - 1) : 16'(CONV_LATER_TICKS - 1)));
    assign acc_sum  = q.acc + 26'(adc_sample_i);
    assign volt_new = q.first ? 12'(acc_sum >> FIRST_SH) : 12'(acc_sum >> LATER_SH);

    // Word completes on the eighth rise of the odd byte of a pair
    assign wword  = {q.hold, q.shift[6:0], q.sda_sy[1]};
    assign waddr  = {q.ptr[7:1], 1'b0};
    assign commit = scl_rise && q.phase == fg_pkg::PH_WDATA && q.ptr[0]
                    && q.hold_ok && q.bit_cnt == 4'h7;
    assign por    = commit && waddr == `FG_ADDR_RESET && wword == `FG_POR_CMD;
    assign qs_req = (~sel & ext_edge)
                    | (commit && waddr == `FG_ADDR_QSTART
                       && wword == `FG_QSTART_CMD);
    assign rd_word = reg_word(q.ptr, q.volt, q.soc, q.comp);

    // Next-state logic for the whole block
    always_comb begin
        n = q;
        n.scl_sy = {q.scl_sy[0], twi_i.scl};
        n.sda_sy = {q.sda_sy[0], twi_i.sda};
        n.sel_sy = {q.sel_sy[0], clock_source_select_i};
        n.scl_p  = q.scl_sy[1];
        n.sda_p  = q.sda_sy[1];

        // Internal divider held at zero while the pin is the timebase
        if (int_osc_en_o && q.div != 9'(DIV_CYC - 1)) begin
            n.div = q.div + 9'h001;
        end else begin
            n.div = 9'h000;
        end

        // Sleep entry after both lines sit low; wake on any rise
        if (q.asleep) begin
            n.sleep_cnt = '0;
            if (scl_rise || sda_rise) begin
                n.asleep = 1'b0;
            end
        end else if (!q.scl_sy[1] && !q.sda_sy[1]) begin
            if (tick) begin
                if (q.sleep_cnt == 17'(SLEEP_TICKS - 1)) begin
                    n.asleep = 1'b1;
                end else begin
                    n.sleep_cnt = q.sleep_cnt + 17'h00001;
                end
            end
        end else begin
            n.sleep_cnt = '0;
        end

        // Averaging periods; nothing advances without a tick
        if (tick) begin
            n.acc      = acc_sum;
            n.conv_cnt = q.conv_cnt + 16'h0001;
        end
        if (conv_end) begin
            n.volt      = volt_new;
            n.acc       = '0;
            n.conv_cnt  = '0;
            n.first     = 1'b0;
            n.soc_valid = 1'b1;
            // First estimate straight from voltage, later ones converge
            if (q.first) begin
                n.soc = soc_map(volt_new);
            end else begin
                n.soc = sat16(int'(q.soc)
                        + ((int'(soc_map(volt_new)) - int'(q.soc)) >>> 2));
            end
        end
        if (qs_req) begin
            n.acc      = '0;
            n.conv_cnt = '0;
            n.first    = 1'b1;
        end

        // Two-wire slave
        if (bus_start) begin
            n.phase   = fg_pkg::PH_ADDR;
            n.bit_cnt = 4'h0;
            n.oe      = 1'b0;
            n.hold_ok = 1'b0;
        end else if (bus_stop) begin
            n.phase   = fg_pkg::PH_IDLE;
            n.oe      = 1'b0;
            n.hold_ok = 1'b0;
        end else if (scl_rise && q.phase != fg_pkg::PH_IDLE
                     && q.phase != fg_pkg::PH_SKIP) begin
            if (q.bit_cnt < 4'h8) begin
                n.shift   = {q.shift[6:0], q.sda_sy[1]};
                n.bit_cnt = q.bit_cnt + 4'h1;
            end else begin
                n.bit_cnt = 4'h9;
                // Master refusal ends a read
                if (q.phase == fg_pkg::PH_RDATA && q.sda_sy[1]) begin
                    n.phase = fg_pkg::PH_SKIP;
                end
            end
        end else if (!q.scl_sy[1] && q.scl_p && q.phase != fg_pkg::PH_IDLE) begin
            if (q.phase == fg_pkg::PH_SKIP) begin
                n.oe = 1'b0;
            end else if (q.bit_cnt == 4'h8) begin
                unique case (q.phase)
                    fg_pkg::PH_ADDR: begin
                        if (q.shift[7:1] == `FG_SLAVE_ADDR) begin
                            n.oe    = 1'b1;
                            n.phase = q.shift[0] ? fg_pkg::PH_RDATA : fg_pkg::PH_PTR;
                        end else begin
                            n.phase = fg_pkg::PH_SKIP;
                        end
                    end
                    fg_pkg::PH_PTR: begin
                        n.oe    = 1'b1;
                        n.ptr   = q.shift;
                        n.phase = fg_pkg::PH_WDATA;
                    end
                    fg_pkg::PH_WDATA: begin
                        n.oe      = 1'b1;
                        n.hold    = q.shift;
                        n.hold_ok = ~q.ptr[0];
                        n.ptr     = q.ptr + 8'h01;
                    end
                    fg_pkg::PH_RDATA: begin
                        n.oe  = 1'b0;
                        n.ptr = q.ptr + 8'h01;
                    end
                    default: begin
                        n.oe = 1'b0;
                    end
                endcase
            end else if (q.bit_cnt == 4'h9) begin
                n.bit_cnt = 4'h0;
                n.oe      = 1'b0;
                // Low byte snapped with the high byte so a pair never tears
                if (q.phase == fg_pkg::PH_RDATA) begin
                    n.tx      = q.ptr[0] && q.snap_ok ? q.snap
                              : (q.ptr[0] ? rd_word[7:0] : rd_word[15:8]);
                    n.snap    = rd_word[7:0];
                    n.snap_ok = ~q.ptr[0];
                    n.oe      = q.ptr[0] && q.snap_ok ? ~q.snap[7]
                              : ~(q.ptr[0] ? rd_word[7] : rd_word[15]);
                end
            end else if (q.phase == fg_pkg::PH_RDATA) begin
                n.tx = {q.tx[6:0], 1'b0};
                n.oe = ~q.tx[6];
            end
        end

        // Register writes land only as whole words
        if (commit && waddr == `FG_ADDR_COMP) begin
            n.comp = wword;
        end

        // Soft power-on reset wins over everything, bus released
        if (por) begin
            n = fg_pkg::GAUGE_RST;
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q <= fg_pkg::GAUGE_RST;
        end else begin
            q <= n;
        end
    end

    // Open-drain data line: only ever pulls low
    assign sda_o    = 1'b0;
    assign sda_oe_o = q.oe;
    assign asleep_o = q.asleep;

    // Checks
    property p_pin_qs;
        @(posedge clk_i) disable iff (sys_rst_i)
        (!sel && ext_edge && !por) |=> (q.first && q.conv_cnt == 16'h0000);
    endproperty
    a_pin_qs: assert property (p_pin_qs) else $error("pin edge missed quick-start");

    property p_sw_qs;
        @(posedge clk_i) disable iff (sys_rst_i)
        (commit && waddr == `FG_ADDR_QSTART && wword == `FG_QSTART_CMD)
        |=> (q.first && q.acc == 26'h0);
    endproperty
    a_sw_qs: assert property (p_sw_qs) else $error("quick-start write ignored");

    property p_first_est;
        @(posedge clk_i) disable iff (sys_rst_i)
        (conv_end && q.first && !qs_req && !por)
        |=> (!q.first && q.soc == soc_map(q.volt) && q.soc_valid);
    endproperty
    a_first_est: assert property (p_first_est) else $error("first estimate wrong");

    property p_osc_off;
        @(posedge clk_i) disable iff (sys_rst_i)
        sel |=> (q.div == 9'h000 || !$past(sel)) ##1 (q.div == 9'h000 || !$past(sel));
    endproperty
    a_osc_off: assert property (p_osc_off) else $error("oscillator ran");

    property p_sleep_entry;
        @(posedge clk_i) disable iff (sys_rst_i)
        $rose(q.asleep) |-> ($past(q.sleep_cnt) == 17'(SLEEP_TICKS - 1)
                             && !$past(q.scl_sy[1]) && !$past(q.sda_sy[1]));
    endproperty
    a_sleep_entry: assert property (p_sleep_entry) else $error("early sleep");

    property p_halt;
        @(posedge clk_i) disable iff (sys_rst_i || por)
        (q.asleep && !qs_req) |=> ($stable(q.conv_cnt) && $stable(q.soc));
    endproperty
    a_halt: assert property (p_halt) else $error("gauge ran in sleep");

    property p_wake;
        @(posedge clk_i) disable iff (sys_rst_i)
        (q.asleep && (scl_rise || sda_rise)) |=> !q.asleep;
    endproperty
    a_wake: assert property (p_wake) else $error("no wake on edge");

    property p_por;
        @(posedge clk_i) disable iff (sys_rst_i)
        por |=> (q.comp == `FG_COMP_RST && q.phase == fg_pkg::PH_IDLE && q.first);
    endproperty
    a_por: assert property (p_por) else $error("soft reset incomplete");

    property p_no_ack;
        @(posedge clk_i) disable iff (sys_rst_i)
        por |=> !sda_oe_o [*4];
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("ack after reset write");

    property p_partial;
        @(posedge clk_i) disable iff (sys_rst_i)
        (bus_start || bus_stop) |=> (!q.hold_ok ##1 !commit);
    endproperty
    a_partial: assert property (p_partial) else $error("partial word kept");

    c_sleep: cover property (@(posedge clk_i) disable iff (sys_rst_i) $rose(q.asleep));
    c_sw_qs: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        commit && waddr == `FG_ADDR_QSTART);
    c_por:   cover property (@(posedge clk_i) disable iff (sys_rst_i) por);
    c_read:  cover property (@(posedge clk_i) disable iff (sys_rst_i)
        q.phase == fg_pkg::PH_RDATA && q.bit_cnt == 4'h8);

endmodule

// ===== tb/fuel_gauge_control_regs_tb.sv
// Self-checking bench for the fuel gauge control block
`timescale 1ns/100ps

module fuel_gauge_control_regs_tb;
    localparam int FIRST = 16;
    localparam int SLP   = 32;
    localparam int TICK  = 305;

    logic         clk_i     = 1'b0;
    logic         lclk      = 1'b0;
    logic         sys_rst_i = 1'b1;
    logic         pin_en    = 1'b0;
    logic         qs_pin    = 1'b0;
    logic         sel       = 1'b0;
    logic [11:0]  adc       = 12'h000;
    logic         sda_o;
    logic         sda_oe_o;
    logic         osc_en;
    logic         asleep;
    fg_pkg::twi_s twi;
    logic [15:0]  rv;
    logic [15:0]  wv;
    logic [11:0]  lv;
    logic         ack;
    int           miscompares = 0;
    int           n_compared  = 0;
    int           k;

    // System clock and an unrelated event-pin clock
    always #50 clk_i = ~clk_i;
    always #80 lclk = ~lclk;

    // Short counts keep the run brief; revision code is arbitrary
    fuel_gauge_control_regs #(.CONV_FIRST_TICKS(FIRST), .CONV_LATER_TICKS(64),
        .SLEEP_TICKS(SLP), .REVISION(16'h005a)) fuel_gauge_control_regs_inst (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .event_clock_pin_i((pin_en & lclk) | qs_pin),
        .clock_source_select_i(sel), .twi_i(twi), .adc_sample_i(adc),
        .sda_o(sda_o), .sda_oe_o(sda_oe_o), .int_osc_en_o(osc_en), .asleep_o(asleep));

    // A driven high level would read as released, so a wrong line value shows up
    twi_master_model twi_master_model_inst (.clk_i(clk_i), .sda_oe_i(sda_oe_o & ~sda_o),
        .twi_o(twi));

    // First charge estimate: linear map, clamped instead of wrapping
    function automatic logic [15:0] soc_of(input logic [11:0] v);
        int s;
        s = (int'(v) - 2400) * 68;
        return (s < 0) ? 16'h0000 : (s > 65535) ? 16'hffff : 16'(s);
    endfunction

    task automatic chk(input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            miscompares++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Restart estimation by pin edge or command, then check first results
    task automatic qs(input logic [11:0] v, input logic by_pin);
        adc = v;
        lv = v;
        cyc(2);
        if (by_pin) begin
            // Clean single pulse; the fast link clock could give two rises
            qs_pin = 1'b1;
            cyc(4);
            qs_pin = 1'b0;
        end else begin
            twi_master_model_inst.wr(8'h06, 16'h4000, 1'b1, ack);
        end
        cyc(FIRST * TICK + 400);
        twi_master_model_inst.rd(8'h02, rv);
        chk({v, 4'h0}, rv);
        twi_master_model_inst.rd(8'h04, rv);
        chk(soc_of(v), rv);
        $display("quick-start test v=%h done", v);
    endtask

    // Main sequence
    initial begin
        void'($urandom(27));
        repeat (6) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        cyc(4);
        twi_master_model_inst.rd(8'h04, rv);
        chk(16'h0000, rv);
        twi_master_model_inst.rd(8'h0c, rv);
        chk(16'h9700, rv);
        twi_master_model_inst.rd(8'h08, rv);
        chk(16'h005a, rv);
        twi_master_model_inst.rd(8'h0a, rv);  // Reserved, any value
        wv = 16'($urandom);
        twi_master_model_inst.wr(8'h0c, wv, 1'b1, ack);
        twi_master_model_inst.wr(8'h0c, ~wv, 1'b0, ack);
        twi_master_model_inst.rd(8'h0c, rv);
        chk(wv, rv);
        // Reserved reset value: acknowledged, nothing reset
        twi_master_model_inst.wr(8'hfe, 16'h5401, 1'b1, ack);
        chk(16'h0001, {15'h0000, ack});
        twi_master_model_inst.rd(8'h0c, rv);
        chk(wv, rv);
        $display("register test done");
        // Corner samples: mid, below empty, top, then random
        qs(12'hc80, 1'b0);
        qs(12'h800, 1'b1);
        qs(12'hfff, 1'b0);
        qs(12'h960 + 12'($urandom_range(0, 1023)), 1'b1);
        // External timebase stops the internal oscillator
        sel = 1'b1;
        cyc(5);
        pin_en = 1'b1;
        cyc(40);
        chk(16'h0000, {15'h0000, osc_en});
        pin_en = 1'b0;
        cyc(10);
        sel = 1'b0;
        cyc(5);
        chk(16'h0001, {15'h0000, osc_en});
        $display("clock select test done");
        // Sleep entry window, halt, wake on a clock-line rise
        twi_master_model_inst.lines(1'b0, 1'b1);
        cyc(2);
        twi_master_model_inst.lines(1'b0, 1'b0);
        k = 0;
        while (asleep !== 1'b1 && k < SLP * TICK + 400) begin
            cyc(1);
            k++;
        end
        if (asleep !== 1'b1) begin
            miscompares++;
            summarize();
        end
        chk(16'h0001, {15'h0000, k > SLP * TICK - 400});
        chk(16'h0000, {15'h0000, osc_en});
        twi_master_model_inst.lines(1'b1, 1'b0);
        cyc(5);
        chk(16'h0000, {15'h0000, asleep});
        twi_master_model_inst.lines(1'b1, 1'b1);
        cyc(4);
        twi_master_model_inst.rd(8'h04, rv);
        chk(soc_of(lv), rv);  // Estimate kept across sleep
        $display("sleep test done");
        // Full reset command: no acknowledge, defaults back
        twi_master_model_inst.wr(8'hfe, 16'h5400, 1'b1, ack);
        chk(16'h0000, {15'h0000, ack});
        twi_master_model_inst.rd(8'h0c, rv);
        chk(16'h9700, rv);
        twi_master_model_inst.rd(8'h04, rv);
        chk(16'h0000, rv);
        $display("reset command test done");
        summarize();
    end
endmodule

// ===== tb/twi_master_model.sv
// Two-wire bus master model that drives the gauge's bus lines
`timescale 1ns/100ps

module twi_master_model (
    input  wire logic    clk_i,     // System clock
    input  wire logic    sda_oe_i,  // Device pulls data low
    output fg_pkg::twi_s twi_o      // Resolved line levels
);
    logic scl_m;
    logic sda_m;

    // Pull-up: the data line is low if either party pulls it
    assign twi_o.scl = scl_m;
    assign twi_o.sda = sda_m & ~sda_oe_i;

    // Released lines rest high at time zero
    initial begin
        scl_m = 1'b1;
        sda_m = 1'b1;
    end

    // Whole-clock waits keep line changes off the sampling edge
    task automatic hw(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // Raw line levels, used for sleep entry and wake
    task automatic lines(input logic s, input logic d);
        scl_m = s;
        sda_m = d;
    endtask

    // One bit; the answer is read at the end of the high phase
    task automatic bitx(input logic b, output logic r);
        sda_m = b;
        hw(4);
        scl_m = 1'b1;
        hw(6);
        r = twi_o.sda;
        scl_m = 1'b0;
        hw(2);
    endtask

    // Start or repeated start
    task automatic start();
        sda_m = 1'b1;
        hw(2);
        scl_m = 1'b1;
        hw(4);
        sda_m = 1'b0;
        hw(4);
        scl_m = 1'b0;
        hw(2);
    endtask

    // Stop
    task automatic stop();
        sda_m = 1'b0;
        hw(2);
        scl_m = 1'b1;
        hw(4);
        sda_m = 1'b1;
        hw(4);
    endtask

    // Byte out, most significant bit first
    task automatic send(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], r);
        end
        bitx(1'b1, r);
        ack = ~r;
    endtask

    // Byte in; the master answers with mack
    task automatic recv(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'b1, d[i]);
        end
        bitx(~mack, r);
    endtask

    // Word write, high byte first; full low stops after the high byte
    task automatic wr(input logic [7:0] p, input logic [15:0] w, input logic full,
                      output logic ack);
        start();
        send(8'h6c, ack);
        send(p, ack);
        send(w[15:8], ack);
        if (full) begin
            send(w[7:0], ack);  // A missing acknowledge is tolerated
        end
        stop();
    endtask

    // Word read through a repeated start
    task automatic rd(input logic [7:0] p, output logic [15:0] w);
        logic a;
        start();
        send(8'h6c, a);
        send(p, a);
        start();
        send(8'h6d, a);
        recv(1'b1, w[15:8]);
        recv(1'b0, w[7:0]);
        stop();
    endtask
endmodule
